// ---- src/selftest_regs.vh ----
// constants for the power-up self-test and preset sequencer
`ifndef SELFTEST_REGS_VH
`define SELFTEST_REGS_VH
// timing
`define CLK_HZ 20000000
`define DARK_TIME_MS 3000
`define DARK_CYCLES ((`CLK_HZ / 1000) * `DARK_TIME_MS)
`define TONE_TIME_MS 200
`define TONE_CYCLES ((`CLK_HZ / 1000) * `TONE_TIME_MS)
// register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_IRQ_STAT 8'h08
`define REG_IRQ_EN 8'h0C
`define REG_IRQ_CLR 8'h10
`define REG_FAULT 8'h14
`define REG_LAMPS 8'h18
// ctrl bits
`define CTRL_TONE_EN 0
`define CTRL_RESTART 1
// irq bits
`define IRQ_FAULT 0
`define IRQ_DONE 1
// preset values
`define PRESET_POINTS 16'h0200
`define PRESET_HSCALE 16'h0001
`define UNIT_SECONDS 2'h1
`define UNIT_VOLTS 2'h2
// fault codes on horizontal lamps {alt, chopped_mode_lamp, b}
`define HCODE_RAM 3'h1
`define HCODE_ROM 3'h2
`define HCODE_CLOCK 3'h3
`define HCODE_DISPLAY 3'h4
`endif

// ---- src/powerup_selftest_preset_sequencer.v ----
// power-up lamp sequence, self-test runner, fault display and preset loader
// Function
// (R1) On a cold power-up with no backup power the block runs four self-tests.
// (R2) For about three seconds after power-up mode, intensity and red lamps stay dark.
// (R3) After the dark interval all mode, intensity and red lamps light together.
// (R4) A failed test lights all vertical lamps and a per-test code on horizontal lamps.
// (R5) While a fault code shows the sequence holds until any mode button is pressed.
// (R6) On success the warning tone sounds only when the rear tone switch is on.
// (R7) On success red, S and A lamps go off, vertical except LEFT, horizontal except B.
// (R8) On success a completion message is written to the readout.
// (R9) After success program memory is cleared and stored display set off, vectors.
// (R10) After success the points-per-waveform setting becomes 512.
// (R11) After success the working waveform selector becomes zero.
// (R12) After success every point of every waveform memory is written with zero.
// (R13) After success every waveform memory's vertical zero reference becomes zero.
// (R14) After success horizontal scale is 1, horizontal unit seconds, vertical unit volts.
// (R15) After success all constant registers are cleared and the logic output goes high.
// (R16) The dark interval is timed by a counter on the system clock of about three seconds.
// (R17) Presets are applied only after the last test and each write happens once.
`timescale 1ns/100ps
`include "selftest_regs.vh"
module powerup_selftest_preset_sequencer #(
   parameter DARK_CYCLES = `DARK_CYCLES,
   parameter TONE_CYCLES = `TONE_CYCLES,
   parameter PROG_AW = 10,
   parameter WAVE_AW = 12,
   parameter WAVE_N = 4,
   parameter CONST_AW = 7,
   parameter CONST_N = 100
) (
   // clock and reset
   input wire sys_clk,
   input wire reset_n,
   // power and panel inputs
   input wire backup_power,
   input wire tone_switch_on,
   input wire [3:0] vert_buttons,
   input wire [3:0] horiz_buttons,
   // self-test engine handshake
   output reg test_start,
   output reg [1:0] test_index,
   input wire test_done,
   input wire test_fail,
   // lamps: vertical {left,alt,chopped_mode_lamp,right}, horizontal {alt,chopped_mode_lamp,b,a}
   output reg [3:0] vert_lamps,
   output reg [3:0] horiz_lamps,
   output reg [3:0] intensity_lamps,
   output reg [7:0] red_lamps,
   output reg tone,
   output reg msg_write,
   // preset memory write port
   output reg mem_we,
   output reg [2:0] mem_sel,
   output reg [15:0] mem_addr,
   output reg [15:0] mem_wdata,
   // preset state outputs
   output reg stored_display_on,
   output reg vector_mode,
   output reg [15:0] points_per_wave,
   output reg [1:0] working_waveform_select,
   output reg logic_out,
   output reg sequence_done,
   // avalon-mm slave
   input wire [7:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   output reg [31:0] avs_readdata,
   output reg avs_waitrequest,
   output reg irq
);
   // states
   localparam S_IDLE = 9'h001;
   localparam S_DARK = 9'h002;
   localparam S_LIT = 9'h004;
   localparam S_TEST = 9'h008;
   localparam S_WAIT = 9'h010;
   localparam S_FAULT = 9'h020;
   localparam S_OK = 9'h040;
   localparam S_PRESET = 9'h080;
   localparam S_DONE = 9'h100;
   // memory selectors
   localparam M_PROG = 3'h0;
   localparam M_WAVE = 3'h1;
   localparam M_VZR = 3'h2;
   localparam M_HSC = 3'h3;
   localparam M_UNIT = 3'h4;
   localparam M_CONST = 3'h5;
   localparam M_END = 3'h6;

   // sequencer state, dark counter and captured fault data
   reg [8:0] state_q;
   reg [31:0] cnt_q;
   reg [1:0] idx_q;
   reg [2:0] hcode_q;
   reg [2:0] fault_seen_q;
   reg [3:0] fault_mask_q;
   // software-visible control and interrupt state
   reg tone_en_q;
   reg restart_q;
   reg [1:0] irq_stat_q;
   reg [1:0] irq_en_q;
   // preset walker position and tone timer
   reg [15:0] paddr_q;
   reg [2:0] psel_q;
   reg [31:0] tcnt_q;

   // horizontal fault code per test
   function [2:0] fault_code;
      input [1:0] idx;
      begin
         case (idx)
            2'd0: fault_code = `HCODE_RAM;
            2'd1: fault_code = `HCODE_ROM;
            2'd2: fault_code = `HCODE_CLOCK;
            default: fault_code = `HCODE_DISPLAY;
         endcase
      end
   endfunction

   // last address of each preset region
   function [15:0] region_last;
      input [2:0] sel;
      begin
         case (sel)
            M_PROG: region_last = (16'h0001 << PROG_AW) - 16'h0001;
            M_WAVE: region_last = (16'h0001 << WAVE_AW) * WAVE_N[15:0] - 16'h0001;
            M_CONST: region_last = CONST_N[15:0] - 16'h0001;
            default: region_last = WAVE_N[15:0] - 16'h0001;
         endcase
      end
   endfunction

   // event pulses from the sequencer
   wire ev_fault = (state_q == S_WAIT) && test_done && test_fail;
   wire ev_done = (state_q == S_PRESET) && (psel_q == M_END);
   wire any_button = (|vert_buttons) | (|horiz_buttons);
   wire bus_wr = avs_write && !avs_waitrequest;

   // main sequencer
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= S_IDLE;
         cnt_q <= 32'h00000000;
         idx_q <= 2'h0;
         hcode_q <= 3'h0;
         fault_seen_q <= 3'h0;
         fault_mask_q <= 4'h0;
         paddr_q <= 16'h0000;
         psel_q <= M_PROG;
      end else begin
         case (state_q)
            S_IDLE: begin
               // memory kept alive by backup: no test, no preset
               if (!backup_power) begin // (R1)
                  state_q <= S_DARK;
               end else begin
                  state_q <= S_DONE;
               end
               cnt_q <= 32'h00000000;
            end
            S_DARK: begin
               // 32-bit count spans the whole interval at the default clock
               if (cnt_q >= DARK_CYCLES - 1) begin // (R16)
                  state_q <= S_LIT;
               end else begin
                  cnt_q <= cnt_q + 32'h00000001;
               end
            end
            S_LIT: begin
               // lamps all light here, the first test follows
               idx_q <= 2'h0;
               state_q <= S_TEST;
            end
            // start strobe is raised by the output process
            S_TEST: state_q <= S_WAIT;
            S_WAIT: begin
               // verdict only trusted while test_done is high
               if (test_done) begin
                  if (test_fail) begin
                     hcode_q <= fault_code(idx_q); // (R4)
                     fault_seen_q <= fault_code(idx_q);
                     fault_mask_q[idx_q] <= 1'b1;
                     state_q <= S_FAULT;
                  end else if (idx_q == 2'd3) begin
                     state_q <= S_OK;
                  end else begin
                     idx_q <= idx_q + 2'h1;
                     state_q <= S_TEST;
                  end
               end
            end
            S_FAULT: begin
               // hold until operator presses a mode button
               // limitation: a button already held on entry counts as a press
               if (any_button) begin // (R5)
                  hcode_q <= 3'h0;
                  if (idx_q == 2'd3) begin
                     state_q <= S_OK;
                  end else begin
                     idx_q <= idx_q + 2'h1;
                     state_q <= S_TEST;
                  end
               end
            end
            S_OK: begin
               // presets start from the first region
               paddr_q <= 16'h0000;
               psel_q <= M_PROG;
               state_q <= S_PRESET;
            end
            S_PRESET: begin
               // one write per address, walking each region once
               if (psel_q == M_END) begin // (R17)
                  state_q <= S_DONE;
               end else if (paddr_q == region_last(psel_q)) begin
                  paddr_q <= 16'h0000;
                  psel_q <= psel_q + 3'h1;
               end else begin
                  paddr_q <= paddr_q + 16'h0001;
               end
            end
            S_DONE: begin
               // restart honoured only here, a mid-run request is lost
               if (restart_q) begin
                  state_q <= S_IDLE;
                  fault_mask_q <= 4'h0;
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   // lamp, tone and preset outputs, all registered
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         vert_lamps <= 4'h0;
         horiz_lamps <= 4'h0;
         intensity_lamps <= 4'h0;
         red_lamps <= 8'h00;
         tone <= 1'b0;
         tcnt_q <= 32'h00000000;
         msg_write <= 1'b0;
         test_start <= 1'b0;
         test_index <= 2'h0;
         mem_we <= 1'b0;
         mem_sel <= 3'h0;
         mem_addr <= 16'h0000;
         mem_wdata <= 16'h0000;
         stored_display_on <= 1'b0;
         vector_mode <= 1'b0;
         points_per_wave <= 16'h0000;
         working_waveform_select <= 2'h0;
         logic_out <= 1'b0;
         sequence_done <= 1'b0;
      end else begin
         // strobes default low; test_start and msg_write last a single cycle, mem_we stays high for the whole preset walk
         test_start <= (state_q == S_TEST);
         test_index <= idx_q;
         msg_write <= 1'b0;
         mem_we <= 1'b0;
         case (state_q)
            S_IDLE, S_DARK: begin
               // dark interval keeps panel lamps off
               vert_lamps <= 4'h0; // (R2)
               horiz_lamps <= 4'h0;
               intensity_lamps <= 4'h0;
               red_lamps <= 8'h00;
               sequence_done <= 1'b0;
            end
            S_LIT: begin
               vert_lamps <= 4'hF; // (R3)
               horiz_lamps <= 4'hF;
               intensity_lamps <= 4'hF;
               red_lamps <= 8'hFF;
            end
            S_FAULT: begin
               vert_lamps <= 4'hF; // (R4)
               horiz_lamps <= {hcode_q, 1'b0};
            end
            S_OK: begin
               // intensity {s,a,x,y}: s and a go off
               red_lamps <= 8'h00; // (R7)
               intensity_lamps <= intensity_lamps & 4'h3;
               vert_lamps <= 4'h8;
               horiz_lamps <= 4'h2;
               msg_write <= 1'b1; // (R8)
               if (tone_switch_on && tone_en_q) begin // (R6)
                  tone <= 1'b1;
                  tcnt_q <= 32'h00000000;
               end
            end
            S_PRESET: begin
               if (psel_q != M_END) begin // (R17)
                  mem_we <= 1'b1;
                  mem_sel <= psel_q;
                  mem_addr <= paddr_q;
                  case (psel_q)
                     M_HSC: mem_wdata <= `PRESET_HSCALE; // (R14)
                     M_UNIT: mem_wdata <= {12'h000, `UNIT_VOLTS, `UNIT_SECONDS}; // (R14)
                     // prog (R9), wave (R12), vzr (R13), const (R15) all zero
                     default: mem_wdata <= 16'h0000;
                  endcase
               end else begin
                  stored_display_on <= 1'b0; // (R9)
                  vector_mode <= 1'b1;
                  points_per_wave <= `PRESET_POINTS; // (R10)
                  working_waveform_select <= 2'h0; // (R11)
                  logic_out <= 1'b1; // (R15)
                  sequence_done <= 1'b1;
               end
            end
            // other states keep the lamps as last set
            default: begin
            end
         endcase
         // tone length
         if (tone && state_q != S_OK) begin
            if (tcnt_q >= TONE_CYCLES - 1) begin
               tone <= 1'b0;
            end else begin
               tcnt_q <= tcnt_q + 32'h00000001;
            end
         end
      end
   end

   // avalon slave: one wait cycle per access, readdata valid with waitrequest low
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h00000000;
         tone_en_q <= 1'b1;
         restart_q <= 1'b0;
         irq_en_q <= 2'h0;
         irq_stat_q <= 2'h0;
         irq <= 1'b0;
      end else begin
         restart_q <= 1'b0;
         avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
         // data captured in the wait cycle so it stands with waitrequest low
         if (avs_read && avs_waitrequest) begin
            case (avs_address)
               `REG_CTRL: avs_readdata <= {31'h0, tone_en_q};
               `REG_STATUS: avs_readdata <= {20'h0, fault_mask_q, state_q[8:1]};
               `REG_IRQ_STAT: avs_readdata <= {30'h0, irq_stat_q};
               `REG_IRQ_EN: avs_readdata <= {30'h0, irq_en_q};
               `REG_FAULT: avs_readdata <= {29'h0, fault_seen_q};
               `REG_LAMPS: avs_readdata <= {12'h0, red_lamps, intensity_lamps,
                                            horiz_lamps, vert_lamps};
               default: avs_readdata <= 32'h00000000;
            endcase
         end
         // writes land only in the cycle waitrequest is low
         if (bus_wr && avs_address == `REG_CTRL) begin
            tone_en_q <= avs_writedata[`CTRL_TONE_EN];
            restart_q <= avs_writedata[`CTRL_RESTART];
         end
         if (bus_wr && avs_address == `REG_IRQ_EN) begin
            irq_en_q <= avs_writedata[1:0];
         end
         // set wins over clear
         irq_stat_q[`IRQ_FAULT] <= ev_fault | (irq_stat_q[`IRQ_FAULT] &
            !(bus_wr && avs_address == `REG_IRQ_CLR && avs_writedata[`IRQ_FAULT]));
         irq_stat_q[`IRQ_DONE] <= ev_done | (irq_stat_q[`IRQ_DONE] &
            !(bus_wr && avs_address == `REG_IRQ_CLR && avs_writedata[`IRQ_DONE]));
         // registered output, so irq lags the status bit by one cycle
         irq <= |(irq_stat_q & irq_en_q);
      end
   end
endmodule

// ---- test/seq_monitor.sv ----
// assertion monitor for the power-up sequencer ports
`timescale 1ns/100ps
module seq_monitor #(parameter DARK_CYCLES = 20) (
   // clock and reset
   input logic sys_clk,
   input logic reset_n,
   // panel and test handshake
   input logic tone_switch_on,
   input logic [3:0] vert_buttons,
   input logic [3:0] horiz_buttons,
   input logic test_start,
   input logic [1:0] test_index,
   input logic test_done,
   input logic test_fail,
   // lamps and tone
   input logic [3:0] vert_lamps,
   input logic [3:0] horiz_lamps,
   input logic [3:0] intensity_lamps,
   input logic [7:0] red_lamps,
   input logic tone,
   input logic msg_write,
   // presets
   input logic mem_we,
   input logic [2:0] mem_sel,
   input logic [15:0] mem_wdata,
   input logic stored_display_on,
   input logic vector_mode,
   input logic [15:0] points_per_wave,
   input logic [1:0] working_waveform_select,
   input logic logic_out,
   input logic sequence_done,
   // register bus
   input logic avs_read,
   input logic avs_write,
   input logic avs_waitrequest
);
   int dark_q;
   logic seen_q;
   logic [2:0] code_w;
   // expected horizontal code of the test now running
   assign code_w = (test_index == 2'h3) ? 3'h4 : {1'b0, test_index} + 3'h1;
   // cycles since reset, saturating so the counter never wraps
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         dark_q <= 0;
         seen_q <= 1'b0;
      end else begin
         if (dark_q < DARK_CYCLES) dark_q <= dark_q + 1;
         if (msg_write) seen_q <= 1'b1;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   sequence s_shown;
      vert_lamps == 4'hF && !horiz_lamps[0] && horiz_lamps != 4'h0;
   endsequence
   sequence s_no_press;
      (vert_buttons == 4'h0 && horiz_buttons == 4'h0) [*3];
   endsequence
   property p_dark;
      dark_q < DARK_CYCLES |-> {vert_lamps, horiz_lamps, intensity_lamps, red_lamps} == 20'h0;
   endproperty
   a_dark: assert property (p_dark)
      else $error("lamps lit in dark interval");
   property p_code;
      test_done && test_fail |-> ##[1:3] s_shown ##0 horiz_lamps[3:1] == code_w;
   endproperty
   a_code: assert property (p_code)
      else $error("wrong fault code");
   property p_hold;
      test_done && test_fail ##1 s_no_press |-> !test_start;
   endproperty
   a_hold: assert property (p_hold)
      else $error("test started without a press");
   property p_tone;
      tone |-> tone_switch_on;
   endproperty
   a_tone: assert property (p_tone)
      else $error("tone with switch off");
   property p_after;
      mem_we |-> seen_q;
   endproperty
   a_after: assert property (p_after)
      else $error("preset write before completion");
   property p_zero;
      mem_we && mem_sel != 3'h3 && mem_sel != 3'h4 |-> mem_wdata == 16'h0000;
   endproperty
   a_zero: assert property (p_zero)
      else $error("nonzero cleared word");
   property p_scale;
      mem_we && mem_sel == 3'h3 |-> mem_wdata == 16'h0001;
   endproperty
   a_scale: assert property (p_scale)
      else $error("bad scale word");
   property p_units;
      mem_we && mem_sel == 3'h4 |-> mem_wdata == 16'h0009;
   endproperty
   a_units: assert property (p_units)
      else $error("bad units word");
   property p_done;
      $rose(sequence_done) |-> points_per_wave == 16'h0200 && working_waveform_select == 2'h0
         && logic_out && !stored_display_on && vector_mode;
   endproperty
   a_done: assert property (p_done)
      else $error("bad preset state");
   property p_wait;
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   a_wait: assert property (p_wait)
      else $error("bus answer late");
endmodule
bind powerup_selftest_preset_sequencer seq_monitor #(.DARK_CYCLES(DARK_CYCLES)) u_mon (
   .sys_clk, .reset_n, .tone_switch_on, .vert_buttons, .horiz_buttons, .test_start,
   .test_index, .test_done, .test_fail, .vert_lamps, .horiz_lamps, .intensity_lamps,
   .red_lamps, .tone, .msg_write, .mem_we, .mem_sel, .mem_wdata, .stored_display_on,
   .vector_mode, .points_per_wave, .working_waveform_select, .logic_out, .sequence_done,
   .avs_read, .avs_write, .avs_waitrequest);

// ---- test/panel_model.sv ----
// far-side model: self-test engine and front-panel operator
`timescale 1ns/100ps
module panel_model (
   // clock
   input logic sys_clk,
   // test engine side
   input logic test_start,
   input logic [1:0] test_index,
   output logic test_done = 1'b0,
   output logic test_fail = 1'b0,
   // panel side
   input logic [3:0] vert_lamps,
   input logic [3:0] horiz_lamps,
   output logic [3:0] vert_buttons = 4'h0,
   output logic [3:0] horiz_buttons = 4'h0,
   // failing tests and answer lag
   input logic [3:0] fail_mask,
   input logic [3:0] lag
);
   logic [1:0] idx_q;
   logic [3:0] seen_q;
   int presses = 0;
   // verdict toggles outside done so a stale value never looks valid
   always @(posedge sys_clk) begin
      if (test_start === 1'b1) begin
         idx_q = test_index;
         repeat (lag) @(posedge sys_clk);
         test_done <= 1'b1;
         test_fail <= fail_mask[idx_q];
         @(posedge sys_clk);
         test_done <= 1'b0;
      end
      test_fail <= ~test_fail;
   end
   // operator presses one mode button per code shown, alternating banks
   always @(posedge sys_clk) begin
      if (vert_lamps == 4'hF && !horiz_lamps[0] && horiz_lamps != 4'h0) begin
         seen_q = horiz_lamps;
         repeat (3) @(posedge sys_clk);
         vert_buttons <= presses[0] ? 4'h2 : 4'h0;
         horiz_buttons <= presses[0] ? 4'h0 : 4'h8;
         presses++;
         repeat (2) @(posedge sys_clk);
         vert_buttons <= 4'h0;
         horiz_buttons <= 4'h0;
         for (int k = 0; k < 20 && horiz_lamps == seen_q; k++) @(posedge sys_clk);
      end
   end
endmodule

// ---- test/tb.sv ----
// self-checking bench for the power-up sequencer
`timescale 1ns/100ps
`include "selftest_regs.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
   $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
   logic sys_clk = 0, reset_n = 0, backup_power = 0, tone_switch_on = 0;
   logic avs_read = 0, avs_write = 0;
   logic [7:0] avs_address = 8'h00, red_lamps;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
   logic [3:0] vert_buttons, horiz_buttons, vert_lamps, horiz_lamps, intensity_lamps;
   logic [3:0] fail_mask = 4'h0, lag = 4'h0;
   logic [1:0] test_index, working_waveform_select;
   logic [2:0] mem_sel;
   logic [15:0] points_per_wave, mem_addr;
   logic test_start, test_done, test_fail, tone, msg_write, mem_we, irq, avs_waitrequest;
   logic stored_display_on, vector_mode, logic_out, sequence_done;
   logic [2:0] codes [4] = '{3'h1, 3'h2, 3'h3, 3'h4};
   int exp_wr [6] = '{4, 16, 4, 4, 4, 4};
   int wr [8];
   int err_total, comparisons, cyc, rel, starts, msgs, tones;
   powerup_selftest_preset_sequencer #(.DARK_CYCLES(20), .TONE_CYCLES(5), .PROG_AW(2),
      .WAVE_AW(2), .CONST_N(4)) u_dut (.sys_clk, .reset_n, .backup_power, .tone_switch_on,
      .vert_buttons, .horiz_buttons, .test_start, .test_index, .test_done, .test_fail,
      .vert_lamps, .horiz_lamps, .intensity_lamps, .red_lamps, .tone, .msg_write, .mem_we,
      .mem_sel, .mem_addr, .mem_wdata(), .stored_display_on, .vector_mode,
      .points_per_wave, .working_waveform_select, .logic_out, .sequence_done, .avs_address,
      .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .irq);
   panel_model u_panel (.sys_clk, .test_start, .test_index, .test_done, .test_fail,
      .vert_lamps, .horiz_lamps, .vert_buttons, .horiz_buttons, .fail_mask, .lag);
   initial forever #25 sys_clk = ~sys_clk;
   // watchdog and event tallies
   always @(posedge sys_clk) begin
      cyc++;
      if (test_start === 1'b1) starts++;
      if (msg_write === 1'b1) msgs++;
      if (tone === 1'b1) tones++;
      if (mem_we === 1'b1) begin
         `CHK(mem_addr, wr[mem_sel])
         wr[mem_sel]++;
      end
      if (cyc == 20000) begin
         err_total++;
         results();
      end
   end
   task automatic results();
      $display("comparisons=%0d err_total=%0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // one bus access; holds the request until waitrequest is sampled low
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      do begin
         @(posedge sys_clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic apply(input logic bk, sw, input logic [3:0] m, l);
      @(posedge sys_clk);
      reset_n <= 1'b0;
      backup_power <= bk;
      tone_switch_on <= sw;
      fail_mask <= m;
      lag <= l;
      repeat (10) @(posedge sys_clk);
      starts = 0;
      msgs = 0;
      tones = 0;
      foreach (wr[i]) wr[i] = 0;
      rel = cyc;
      reset_n <= 1'b1;
   endtask
   task automatic t_pass(input logic sw, input logic [3:0] l);
      apply(1'b0, sw, 4'h0, l);
      repeat (8) @(posedge sys_clk);
      `CHK({vert_lamps, horiz_lamps, intensity_lamps, red_lamps}, 20'h0)
      while (test_start !== 1'b1) @(posedge sys_clk);
      `CHK(cyc - rel > 20, 1'b1)
      @(posedge sys_clk);
      `CHK({vert_lamps, horiz_lamps, intensity_lamps, red_lamps}, 20'hFFFFF)
      while (sequence_done !== 1'b1) @(posedge sys_clk);
      repeat (2) @(posedge sys_clk);
      `CHK(starts, 4)
      `CHK(tones > 0, sw)
      `CHK(msgs, 1)
      `CHK({vert_lamps, horiz_lamps, red_lamps, intensity_lamps[3:2]}, 18'h20800)
      `CHK({stored_display_on, vector_mode, logic_out, working_waveform_select}, 5'h0C)
      `CHK(points_per_wave, 16'h0200)
      foreach (exp_wr[i]) `CHK(wr[i], exp_wr[i])
   endtask
   task automatic t_regs();
      bus(1'b0, `REG_CTRL, 32'h0);
      `CHK(q[`CTRL_TONE_EN], 1'b1)
      bus(1'b0, `REG_IRQ_STAT, 32'h0);
      `CHK(q[`IRQ_DONE], 1'b1)
      `CHK(irq, 1'b0)
      bus(1'b0, `REG_LAMPS, 32'h0);
      `CHK(q, 32'h00000328)
      bus(1'b1, `REG_IRQ_EN, 32'h2);
      repeat (2) @(posedge sys_clk);
      `CHK(irq, 1'b1)
      bus(1'b1, `REG_IRQ_CLR, 32'h2);
      repeat (2) @(posedge sys_clk);
      `CHK(irq, 1'b0)
      bus(1'b0, 8'h40, 32'h0);
      `CHK(q, 32'h0)
      // restart from done reruns the tests and every preset write
      foreach (wr[i]) wr[i] = 0;
      bus(1'b1, `REG_CTRL, 32'h3);
      repeat (3) @(posedge sys_clk);
      `CHK(sequence_done, 1'b0)
      while (sequence_done !== 1'b1) @(posedge sys_clk);
      repeat (2) @(posedge sys_clk);
      `CHK(starts, 8)
      foreach (exp_wr[i]) `CHK(wr[i], exp_wr[i])
   endtask
   task automatic t_faults();
      apply(1'b0, 1'b1, 4'hF, 4'h0);
      for (int i = 0; i < 4; i++) begin
         while (!(test_done === 1'b1 && test_fail === 1'b1)) @(posedge sys_clk);
         repeat (2) @(posedge sys_clk);
         `CHK({vert_lamps, horiz_lamps[3:1]}, {4'hF, codes[i]})
         `CHK(starts, i + 1)
      end
      repeat (10) @(posedge sys_clk);
      `CHK(starts, 4)
      while (sequence_done !== 1'b1) @(posedge sys_clk);
      bus(1'b0, `REG_FAULT, 32'h0);
      `CHK(q, 32'h00000004)
      bus(1'b0, `REG_STATUS, 32'h0);
      `CHK(q[11:8], 4'hF)
      bus(1'b0, `REG_IRQ_STAT, 32'h0);
      `CHK(q[1:0], 2'h3)
   endtask
   task automatic t_backup();
      apply(1'b1, 1'b1, 4'h0, 4'h0);
      repeat (100) @(posedge sys_clk);
      `CHK(starts, 0)
      `CHK(sequence_done, 1'b0)
   endtask
   initial begin
      t_pass(1'b0, 4'h0);
      t_pass(1'b1, 4'h6);
      t_regs();
      t_faults();
      t_backup();
      results();
   end
endmodule
